// File: inc/relay_spi_pkg.sv
// Shared constants and types of the relay driver serial frame protocol
package relay_spi_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int          FRAME_BITS  = 16;
  localparam int          OP_HI       = 15;
  localparam int          OP_LO       = 14;
  localparam int          BANK_HI     = 13;
  localparam int          BANK_LO     = 10;
  localparam int          ROW_HI      = 9;
  localparam int          ROW_LO      = 8;
  localparam int          DATA_HI     = 7;
  localparam int          TAIL_HI     = 1;
  localparam int          FAULT_BIT   = 10;
  localparam int          REG_COUNT   = 64;

  // ----------------------------------------------------------------------
  // Command codes and reply constants
  // ----------------------------------------------------------------------
  localparam logic [1:0]  OP_WRITE     = 2'h2;
  localparam logic [1:0]  OP_BAD_WRITE = 2'h3;
  localparam logic [1:0]  OP_READ      = 2'h1;
  localparam logic [1:0]  OP_BAD_READ  = 2'h0;
  localparam logic [1:0]  READ_TAIL    = 2'h2;
  localparam logic [1:0]  DIAG_TAIL    = 2'h1;
  localparam logic [15:0] FIRST_BASE   = 16'h0400;
  localparam logic [3:0]  BANK_LAST    = 4'h9;
  localparam logic [1:0]  ROW_UNUSED   = 2'h3;
  localparam logic [7:0]  INSTR_RST    = 8'h00;
  localparam logic [7:0]  REG_RST      = 8'h00;
  localparam logic [4:0]  PULSE_MIN    = 5'h10;
  localparam logic [2:0]  BYTE_ALIGNED = 3'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [3:0] bank_select_field;
    logic [1:0] row_select_field;
    logic [7:0] data;
  } reg_write_t;

  typedef enum logic [3:0] {
    RPL_FIRST = 4'h1,
    RPL_DIAG  = 4'h2,
    RPL_READ  = 4'h4,
    RPL_FAULT = 4'h8
  } reply_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h1,
    ST_FRAME = 2'h2
  } link_state_t;

endpackage

// File: logic/relay_spi_frame.sv
// Serial frame decoder, length checker and delayed reply shifter
`timescale 1ns/1ps
module relay_spi_frame
  import relay_spi_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        sclk_pin,
  input  wire logic        si_pin,
  input  wire logic        select_active_low,
  input  wire logic        sw_reset,
  input  wire logic [15:0] status_bits,
  output logic             so_o,
  output logic             so_oe,
  output reg_write_t       wr_o,
  output logic [7:0]       last_instruction_word
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Only a subset of the address space carries registers
  function automatic logic addr_ok(input logic [3:0] bank, input logic [1:0] row);
    addr_ok = (bank <= BANK_LAST) && (row != ROW_UNUSED);
  endfunction

  // Standard diagnosis word, top bit forced low, fault flag inserted
  function automatic logic [15:0] diag_word(input logic [15:0] st, input logic flag);
    logic [15:0] w;
    w = st;
    w[OP_HI] = 1'b0;
    w[FAULT_BIT] = flag;
    diag_word = w;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] sclk_s_q, si_s_q, sel_s_q;
  logic       sclk_f_q, si_f_q, sel_f_q;
  logic       sclk_f_d, si_f_d, sel_f_d;

  // Filtered level moves only when stages two and three agree
  always_comb begin
    sclk_f_d = (sclk_s_q[1] == sclk_s_q[2]) ? sclk_s_q[2] : sclk_f_q;
    si_f_d   = (si_s_q[1] == si_s_q[2]) ? si_s_q[2] : si_f_q;
    sel_f_d  = (sel_s_q[1] == sel_s_q[2]) ? sel_s_q[2] : sel_f_q;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sclk_s_q <= 3'h0;
      si_s_q   <= 3'h0;
      sel_s_q  <= 3'h7;
      sclk_f_q <= 1'b0;
      si_f_q   <= 1'b0;
      sel_f_q  <= 1'b1;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk_pin};
      si_s_q   <= {si_s_q[1:0], si_pin};
      sel_s_q  <= {sel_s_q[1:0], select_active_low};
      sclk_f_q <= sclk_f_d;
      si_f_q   <= si_f_d;
      sel_f_q  <= sel_f_d;
    end
  end

  logic sclk_rise, sclk_fall, frame_start, frame_end;
  link_state_t state_q, state_d;

  // Edges of the filtered link signals
  assign sclk_rise   = sclk_f_d & ~sclk_f_q;
  assign sclk_fall   = ~sclk_f_d & sclk_f_q;
  assign frame_start = (state_q == ST_IDLE) && !sel_f_d;
  assign frame_end   = (state_q == ST_FRAME) && sel_f_d;

  // ----------------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------------
  logic [15:0] rx_q, rx_d, tx_q, tx_d, read_word_q, read_word_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [2:0]  mod_q, mod_d;
  logic        last_si_q, last_si_d, fault_q, fault_d, len_ok;
  logic [7:0]  instr_q, instr_d;
  reply_kind_t kind_q, kind_d;
  reg_write_t  wr_q, wr_d;
  logic [7:0]  mem_q [REG_COUNT];
  logic [3:0]  bank;
  logic [1:0]  row, op, tail;

  assign op     = rx_q[OP_HI:OP_LO];
  assign bank   = rx_q[BANK_HI:BANK_LO];
  assign row    = rx_q[ROW_HI:ROW_LO];
  assign tail   = rx_q[TAIL_HI:0];
  assign len_ok = (cnt_q == PULSE_MIN) && (mod_q == BYTE_ALIGNED);

  // Next state of shifters, counters, reply selection and write strobe
  always_comb begin
    state_d     = state_q;
    rx_d        = rx_q;
    tx_d        = tx_q;
    cnt_d       = cnt_q;
    mod_d       = mod_q;
    last_si_d   = last_si_q;
    fault_d     = fault_q;
    instr_d     = instr_q;
    kind_d      = kind_q;
    read_word_d = read_word_q;
    wr_d        = '0;
    case (state_q)
      ST_IDLE: begin
        if (frame_start) begin
          state_d = ST_FRAME;
          cnt_d   = 5'h0;
          mod_d   = 3'h0;
          // Reply prepared by the previous frame goes out now
          case (kind_q)
            RPL_FIRST: tx_d = FIRST_BASE | {8'h00, instr_q};
            RPL_READ:  tx_d = read_word_q;
            RPL_FAULT: tx_d = diag_word(status_bits, 1'b1);
            default:   tx_d = diag_word(status_bits, fault_q);
          endcase
        end
      end
      ST_FRAME: begin
        if (frame_end) begin
          state_d = ST_IDLE;
          fault_d = !len_ok;
          if (!len_ok) begin
            kind_d = RPL_FAULT;
          end else if (!rx_q[OP_HI] && (tail == DIAG_TAIL)) begin
            kind_d = RPL_DIAG;
          end else if ((op == OP_WRITE) && addr_ok(bank, row)) begin
            kind_d  = RPL_DIAG;
            instr_d = rx_q[DATA_HI:0];
            wr_d    = '{valid: 1'b1, bank_select_field: bank, row_select_field: row, data: rx_q[DATA_HI:0]};
          end else if ((op == OP_READ) && (tail == READ_TAIL) && addr_ok(bank, row)) begin
            kind_d      = RPL_READ;
            read_word_d = {OP_WRITE, bank, row, mem_q[{bank, row}]};
          end else begin
            // 11 writes, 00 reads, bad tails and unused addresses
            kind_d = RPL_FAULT;
          end
        end else begin
          if (sclk_fall) begin
            rx_d      = {rx_q[14:0], si_f_q};
            last_si_d = si_f_q;
            mod_d     = mod_q + 3'h1;
            // Saturating so long chained frames still pass the minimum
            cnt_d     = (cnt_q == PULSE_MIN) ? cnt_q : cnt_q + 5'h1;
          end
          // First bit is already out; later rises step MSB first
          if (sclk_rise && (cnt_q != 5'h0)) begin
            tx_d = {tx_q[14:0], last_si_q};
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // Software reset re-arms the special first reply
    if (sw_reset) begin
      kind_d  = RPL_FIRST;
      fault_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q     <= ST_IDLE;
      rx_q        <= 16'h0000;
      tx_q        <= 16'h0000;
      cnt_q       <= 5'h0;
      mod_q       <= 3'h0;
      last_si_q   <= 1'b0;
      fault_q     <= 1'b1;
      instr_q     <= INSTR_RST;
      kind_q      <= RPL_FIRST;
      read_word_q <= 16'h0000;
      wr_q        <= '0;
    end else begin
      state_q     <= state_d;
      rx_q        <= rx_d;
      tx_q        <= tx_d;
      cnt_q       <= cnt_d;
      mod_q       <= mod_d;
      last_si_q   <= last_si_d;
      fault_q     <= fault_d;
      instr_q     <= instr_d;
      kind_q      <= kind_d;
      read_word_q <= read_word_d;
      wr_q        <= wr_d;
    end
  end

  // Register store, written only by accepted frames
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        mem_q[i] <= REG_RST;
      end
    end else if (wr_d.valid) begin
      mem_q[{wr_d.bank_select_field, wr_d.row_select_field}] <= wr_d.data;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign so_o                  = tx_q[OP_HI];
  assign so_oe                 = (state_q == ST_FRAME);
  assign wr_o                  = wr_q;
  assign last_instruction_word = instr_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic good_end;
  assign good_end = frame_end && len_ok && !sw_reset;

  // Judged on the filtered select itself; the frame-start cycle legally turns the driver on next edge
  oe_idle_a: assert property (sel_f_q |-> !so_oe)
    else $error("serial output driven while deselected");
  first_reply_a: assert property (sw_reset |=> (kind_q == RPL_FIRST) && fault_q)
    else $error("software reset did not arm first reply");
  len_fault_a: assert property (frame_end && !len_ok && !sw_reset |=> fault_q && (kind_q == RPL_FAULT))
    else $error("bad pulse count not flagged");
  bad_write_a: assert property (good_end && (op == OP_BAD_WRITE) |=> (kind_q == RPL_FAULT) && !wr_q.valid)
    else $error("write opening 11 accepted");
  bad_read_a: assert property (good_end && (op == OP_BAD_READ) && (tail != DIAG_TAIL) |=> kind_q == RPL_FAULT)
    else $error("read opening 00 accepted");
  bad_addr_a: assert property (good_end && !addr_ok(bank, row) && (tail != DIAG_TAIL) |=> kind_q == RPL_FAULT)
    else $error("unused address accepted");
  no_write_a: assert property (frame_end && !len_ok |=> !wr_q.valid)
    else $error("write performed for rejected frame");
  diag_flag_a: assert property (frame_start && (kind_q == RPL_DIAG) |=> !so_o && (tx_q[FAULT_BIT] == $past(fault_q)))
    else $error("diagnosis reply malformed");
  first_word_a: assert property (frame_start && (kind_q == RPL_FIRST) |=> tx_q[FAULT_BIT] && (tx_q[DATA_HI:0] == $past(instr_q)))
    else $error("first reply malformed");
  read_next_a: assert property (frame_start && (kind_q == RPL_READ) |=> tx_q == $past(read_word_q))
    else $error("read answer not sent in next transfer");

  write_c: cover property (wr_q.valid);
  read_c:  cover property (good_end && (op == OP_READ) ##1 kind_q == RPL_READ);
  fault_c: cover property (frame_end && !len_ok);
  first_c: cover property (frame_start && (kind_q == RPL_FIRST));

endmodule

// File: bench/spi_master_model.sv
// Behavioural serial master at the far side of the frame block
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic ref_clk,
  output logic      sclk_pin,
  output logic      si_pin,
  output logic      select_active_low,
  input  wire logic so_o,
  input  wire logic so_oe
);
  // ----------------------------------------------------------------------
  // Link timing and idle levels
  // ----------------------------------------------------------------------
  localparam int HALF = 8; // 80 ns half period of the link clock

  // Clock stands low between frames, data pulled down, select pulled up
  initial begin
    sclk_pin          = 1'b0;
    si_pin            = 1'b0;
    select_active_low = 1'b1;
  end

  // One select-low period of n clocks, tx[n-1:0] sent MSB first
  // Caller picks n; only fault scenarios use a count off the byte grid
  // Frame contents follow the command layouts chosen by the caller
  // Reply collected here belongs to the previous frame
  task automatic xfer(input int n, input logic [31:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    select_active_low = 1'b0;
    repeat (40) @(negedge ref_clk); // Lead time with margin
    for (int i = n - 1; i >= 0; i--) begin
      si_pin   = tx[i];
      sclk_pin = 1'b1;
      repeat (HALF) @(negedge ref_clk);
      // Released output reads as the inverse, never a lucky match
      if (n - 1 - i < 16) rx = {rx[14:0], so_oe ? so_o : ~so_o};
      sclk_pin = 1'b0;
      repeat (HALF) @(negedge ref_clk);
    end
    repeat (20) @(negedge ref_clk); // Lag time before select rises
    select_active_low = 1'b1;
    si_pin            = 1'b0;
    repeat (40) @(negedge ref_clk); // Transfer delay, lets decode finish
  endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench of the serial frame decoder
`timescale 1ns/1ps
module tb_top;
  import relay_spi_pkg::*;
  logic        ref_clk;
  logic        srst;
  logic        sclk_pin;
  logic        si_pin;
  logic        select_active_low;
  logic        sw_reset;
  logic        so_o;
  logic        so_oe;
  logic [15:0] status_bits;
  logic [7:0]  last_instruction_word;
  logic [15:0] rx;
  reg_write_t  wr_o;
  reg_write_t  wr_seen;
  int          error_cnt = 0;
  int          compares  = 0;
  int          wr_cnt    = 0;
  int          cyc       = 0;
  localparam logic [31:0] DIAG_REQ = 32'h0000_0001; // Leading 0, tail 01
  localparam logic [31:0] WR_3_1   = 32'h0000_8DA5; // Write bank 3 row 1 data A5
  localparam logic [31:0] RD_3_1   = 32'h0000_4D02; // Read bank 3 row 1, tail 10

  // ----------------------------------------------------------------------
  // Clock, instances and monitors
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  relay_spi_frame relay_spi_frame_i (.ref_clk(ref_clk), .srst(srst), .sclk_pin(sclk_pin), .si_pin(si_pin),
    .select_active_low(select_active_low), .sw_reset(sw_reset), .status_bits(status_bits), .so_o(so_o),
    .so_oe(so_oe), .wr_o(wr_o), .last_instruction_word(last_instruction_word));
  spi_master_model spi_master_model_i (.ref_clk(ref_clk), .sclk_pin(sclk_pin), .si_pin(si_pin),
    .select_active_low(select_active_low), .so_o(so_o), .so_oe(so_oe));

  // Count write pulses; hang guard far above the expected run length
  always @(posedge ref_clk) begin
    if (wr_o.valid === 1'b1) begin
      wr_cnt  <= wr_cnt + 1;
      wr_seen <= wr_o;
    end
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Diagnosis word: top bit clear, fault flag at bit 10
  function automatic logic [15:0] diag(input logic f);
    diag = {1'b0, status_bits[14:11], f, status_bits[9:0]};
  endfunction

  task automatic frame(input int n, input logic [31:0] tx);
    spi_master_model_i.xfer(n, tx, rx);
    check("idle output enable", 16'h0000, {15'h0000, so_oe});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_first;
    frame(16, DIAG_REQ);
    check("first reply", FIRST_BASE | {8'h00, INSTR_RST}, rx);
    frame(16, DIAG_REQ);
    check("second reply", diag(1'b0), rx);
  endtask

  task automatic t_write_read;
    int n0;
    n0 = wr_cnt;
    frame(16, WR_3_1);
    check("write count", 16'(n0 + 1), 16'(wr_cnt));
    check("write word", {1'b0, 1'b1, 4'h3, 2'h1, 8'hA5}, {1'b0, wr_seen});
    check("last instruction", 16'h00A5, {8'h00, last_instruction_word});
    frame(16, RD_3_1);
    check("write reply", diag(1'b0), rx);
    frame(16, DIAG_REQ);
    check("read reply", 16'h8DA5, rx);
  endtask

  task automatic t_length;
    int counts[4] = '{8, 15, 17, 23};
    int n0;
    foreach (counts[k]) begin
      n0 = wr_cnt;
      frame(counts[k], WR_3_1 ^ 32'h0000_00FF);
      frame(16, DIAG_REQ);
      check("length fault reply", diag(1'b1), rx);
      check("length fault writes", 16'(n0), 16'(wr_cnt));
    end
    frame(24, DIAG_REQ);
    check("long frame reply", diag(1'b0), rx);
    frame(16, DIAG_REQ);
    check("after long frame", diag(1'b0), rx);
  endtask

  task automatic t_syntax;
    logic [31:0] bad[4] = '{32'h0000_CD3C, 32'h0000_0D02, 32'h0000_A93C, 32'h0000_4702};
    int n0;
    // New status pattern with bits 15 and 10 low, so a forced flag stands out
    status_bits = 16'h7B18;
    foreach (bad[k]) begin
      n0 = wr_cnt;
      frame(16, bad[k]);
      check("reply before syntax fault", diag(1'b0), rx);
      frame(16, DIAG_REQ);
      check("syntax fault reply", diag(1'b1), rx);
      check("syntax fault writes", 16'(n0), 16'(wr_cnt));
      check("syntax instruction", 16'h00A5, {8'h00, last_instruction_word});
    end
  endtask

  task automatic t_sw_reset;
    sw_reset = 1'b1;
    @(negedge ref_clk);
    sw_reset = 1'b0;
    frame(16, DIAG_REQ);
    check("soft reset reply", FIRST_BASE | 16'h00A5, rx);
    frame(16, DIAG_REQ);
    check("soft reset second", diag(1'b0), rx);
  endtask

  task automatic end_of_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence; status pattern tells the two override bits apart
  initial begin
    srst        = 1'b1;
    sw_reset    = 1'b0;
    status_bits = 16'hA5C3;
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_first();
    t_write_read();
    t_length();
    t_syntax();
    t_sw_reset();
    end_of_test();
  end
endmodule
